// >>> dcir_router.sv
// Interrupt routing and inter-processor channel unit for two CPUs
`timescale 1ns/1ps
`include "dcir_consts.svh"
module dcir_router (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [`DCIR_SRC_N-1:0] src_irq_i,
	input wire logic irq_units_run_i,
	input wire logic [`DCIR_SRC_N-1:0] main_en_i,
	input wire logic [`DCIR_SRC_N*`DCIR_MAIN_PW-1:0] main_prio_i,
	input wire logic [`DCIR_SEC_LINES*`DCIR_SRC_N-1:0] sec_map_i,
	input wire logic [`DCIR_SEC_N-1:0] sec_en_i,
	input wire logic [`DCIR_SEC_N*`DCIR_SEC_PW-1:0] sec_prio_i,
	input wire logic [`DCIR_SEC_SW-1:0] sec_sw_set_i,
	input wire logic [`DCIR_SEC_SW-1:0] sec_sw_clr_i,
	input wire dcir_pkg::dcir_nmi_sel_type main_nmi_sel_i,
	input wire dcir_pkg::dcir_nmi_sel_type sec_nmi_sel_i,
	input wire logic sysfn_main_i,
	input wire logic sysfn_sec_i,
	input wire logic sysfn_debug_port_i,
	input wire logic sysfn_ack_i,
	input wire logic [`DCIR_WAKE_N-1:0] wake_mask_i,
	input wire dcir_pkg::dcir_ipc_req_type ipc_req_main_i,
	input wire dcir_pkg::dcir_ipc_req_type ipc_req_sec_i,
	output logic [`DCIR_SRC_N-1:0] main_irq_o,
	output logic main_top_valid_o,
	output logic [`DCIR_SRC_W-1:0] main_top_id_o,
	output logic [`DCIR_MAIN_PW-1:0] main_top_prio_o,
	output logic [`DCIR_SEC_LINES-1:0] sec_irq_o,
	output logic [`DCIR_SEC_SW-1:0] sec_sw_pend_o,
	output logic sec_top_valid_o,
	output logic [`DCIR_SEC_W-1:0] sec_top_id_o,
	output logic [`DCIR_SEC_PW-1:0] sec_top_prio_o,
	output logic main_nmi_o,
	output logic sec_nmi_o,
	output logic wake_o,
	output dcir_pkg::dcir_ipc_rsp_type ipc_rsp_main_o,
	output dcir_pkg::dcir_ipc_rsp_type ipc_rsp_sec_o,
	output logic [`DCIR_CH_N-1:0] ipc_lock_o,
	output logic [`DCIR_CH_N-1:0] ipc_notify_o,
	output logic [`DCIR_CH_N-1:0] ipc_release_o,
	output logic ipc_irq_main_o,
	output logic ipc_irq_sec_o
);
	// Non-maskable select decode, shared by both CPUs
	function automatic logic nmi_hit(input logic [`DCIR_SRC_N-1:0] src,
			input dcir_pkg::dcir_nmi_sel_type sel);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < `DCIR_NMI_SEL; k++) begin
			if (sel.en[k] && (32'(sel.idx[k]) < `DCIR_SRC_N)) begin
				hit = hit | src[sel.idx[k]];
			end
		end
		return hit;
	endfunction

	// Debug port request arrives from another domain
	logic dbg_meta_reg, dbg_sync_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dbg_meta_reg <= 1'b0;
			dbg_sync_reg <= 1'b0;
		end else begin
			dbg_meta_reg <= sysfn_debug_port_i;
			dbg_sync_reg <= dbg_meta_reg;
		end
	end

	// Routing, priority pick, NMI and wake next values
	logic [`DCIR_SRC_N-1:0] main_irq_reg, main_irq_next, main_pend;
	logic main_top_valid_reg, main_top_valid_next;
	logic [`DCIR_SRC_W-1:0] main_top_id_reg, main_top_id_next;
	logic [`DCIR_MAIN_PW-1:0] main_top_prio_reg, main_top_prio_next, mp;
	logic [`DCIR_SEC_LINES-1:0] sec_irq_reg, sec_irq_next, sec_line;
	logic [`DCIR_SEC_SW-1:0] sw_pend_reg, sw_pend_next;
	logic [`DCIR_SEC_N-1:0] sec_pend;
	logic sec_top_valid_reg, sec_top_valid_next;
	logic [`DCIR_SEC_W-1:0] sec_top_id_reg, sec_top_id_next;
	logic [`DCIR_SEC_PW-1:0] sec_top_prio_reg, sec_top_prio_next, sp;
	logic main_nmi_reg, main_nmi_next, sec_nmi_reg, sec_nmi_next;
	logic sysfn_reg, sysfn_next, wake_reg, wake_next;

	genvar g;
	generate
		for (g = 0; g < `DCIR_SEC_LINES; g++) begin : g_sec_line
			assign sec_line[g] = |(src_irq_i & sec_map_i[g*`DCIR_SRC_N +: `DCIR_SRC_N]);
		end
	endgenerate

	always_comb begin
		main_irq_next = irq_units_run_i ? src_irq_i : '0;
		main_pend = main_irq_next & main_en_i;
		main_top_valid_next = 1'b0;
		main_top_id_next = '0;
		main_top_prio_next = '0;
		for (int i = 0; i < `DCIR_SRC_N; i++) begin
			mp = main_prio_i[i*`DCIR_MAIN_PW +: `DCIR_MAIN_PW];
			if (main_pend[i] && (!main_top_valid_next || mp < main_top_prio_next)) begin
				main_top_valid_next = 1'b1;
				main_top_id_next = `DCIR_SRC_W'(i);
				main_top_prio_next = mp;
			end
		end
		sec_irq_next = irq_units_run_i ? sec_line : '0;
		sw_pend_next = (sw_pend_reg & ~sec_sw_clr_i) | sec_sw_set_i;
		sec_pend = {sw_pend_reg, sec_irq_next} & sec_en_i & {`DCIR_SEC_N{irq_units_run_i}};
		// Four-level pick on the secondary side
		sec_top_valid_next = 1'b0;
		sec_top_id_next = '0;
		sec_top_prio_next = '0;
		for (int j = 0; j < `DCIR_SEC_N; j++) begin
			sp = sec_prio_i[j*`DCIR_SEC_PW +: `DCIR_SEC_PW];
			if (sec_pend[j] && (!sec_top_valid_next || sp < sec_top_prio_next)) begin
				sec_top_valid_next = 1'b1;
				sec_top_id_next = `DCIR_SEC_W'(j);
				sec_top_prio_next = sp;
			end
		end
		sysfn_next = (sysfn_reg & ~sysfn_ack_i) | sysfn_main_i | sysfn_sec_i | dbg_sync_reg;
		main_nmi_next = nmi_hit(src_irq_i, main_nmi_sel_i);
		sec_nmi_next = nmi_hit(src_irq_i, sec_nmi_sel_i) | sysfn_reg;
		wake_next = |(src_irq_i[`DCIR_WAKE_N-1:0] & wake_mask_i);
	end

	// Interrupt state registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			main_irq_reg <= '0;
			main_top_valid_reg <= 1'b0;
			main_top_id_reg <= '0;
			main_top_prio_reg <= '0;
			sec_irq_reg <= '0;
			sw_pend_reg <= '0;
			sec_top_valid_reg <= 1'b0;
			sec_top_id_reg <= '0;
			sec_top_prio_reg <= '0;
			main_nmi_reg <= 1'b0;
			sec_nmi_reg <= 1'b0;
			sysfn_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			main_irq_reg <= main_irq_next;
			main_top_valid_reg <= main_top_valid_next;
			main_top_id_reg <= main_top_id_next;
			main_top_prio_reg <= main_top_prio_next;
			sec_irq_reg <= sec_irq_next;
			sw_pend_reg <= sw_pend_next;
			sec_top_valid_reg <= sec_top_valid_next;
			sec_top_id_reg <= sec_top_id_next;
			sec_top_prio_reg <= sec_top_prio_next;
			main_nmi_reg <= main_nmi_next;
			sec_nmi_reg <= sec_nmi_next;
			sysfn_reg <= sysfn_next;
			wake_reg <= wake_next;
		end
	end

	// Channel state and next values
	logic [`DCIR_CH_N-1:0] lock_reg, lock_next, owner_reg, owner_next;
	logic [`DCIR_CH_N-1:0] ntf_reg, ntf_next, rel_reg, rel_next, tgt_reg, tgt_next;
	logic [`DCIR_CH_N-1:0][`DCIR_DATA_W-1:0] data_reg, data_next;
	logic [`DCIR_CH_N-1:0] ntf_set, rel_set, pend_clr;
	dcir_pkg::dcir_ipc_rsp_type rsp_reg [2];
	dcir_pkg::dcir_ipc_rsp_type rsp_next [2];
	dcir_pkg::dcir_ipc_req_type rq;

	// Main port served first, so it wins a same-cycle acquire race
	always_comb begin
		lock_next = lock_reg;
		owner_next = owner_reg;
		tgt_next = tgt_reg;
		data_next = data_reg;
		ntf_set = '0;
		rel_set = '0;
		pend_clr = '0;
		for (int p = 0; p < 2; p++) begin
			rq = (p == 0) ? ipc_req_main_i : ipc_req_sec_i;
			rsp_next[p].valid = (rq.op != dcir_pkg::IPC_NOP);
			rsp_next[p].ok = 1'b1;
			rsp_next[p].rdata = '0;
			case (rq.op)
				dcir_pkg::IPC_ACQUIRE: begin
					rsp_next[p].ok = !lock_next[rq.chan];
					if (!lock_next[rq.chan]) begin
						lock_next[rq.chan] = 1'b1;
						owner_next[rq.chan] = p[0];
					end
				end
				dcir_pkg::IPC_RELEASE: begin
					rsp_next[p].ok = lock_next[rq.chan] && (owner_next[rq.chan] == p[0]);
					if (rsp_next[p].ok) begin
						lock_next[rq.chan] = 1'b0;
						rel_set[rq.chan] = 1'b1;
						tgt_next[rq.chan] = ~p[0];
					end
				end
				dcir_pkg::IPC_WRITE: data_next[rq.chan] = rq.data;
				dcir_pkg::IPC_READ: rsp_next[p].rdata = data_next[rq.chan];
				dcir_pkg::IPC_NOTIFY: begin
					ntf_set[rq.chan] = 1'b1;
					tgt_next[rq.chan] = ~p[0];
				end
				dcir_pkg::IPC_CLEAR: pend_clr[rq.chan] = 1'b1;
				default: rsp_next[p].ok = 1'b0;
			endcase
		end
		ntf_next = (ntf_reg & ~pend_clr) | ntf_set;
		rel_next = (rel_reg & ~pend_clr) | rel_set;
	end

	// Channel registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_reg <= '0;
			owner_reg <= '0;
			tgt_reg <= '0;
			data_reg <= '0;
			ntf_reg <= '0;
			rel_reg <= '0;
			rsp_reg[0] <= '0;
			rsp_reg[1] <= '0;
		end else begin
			lock_reg <= lock_next;
			owner_reg <= owner_next;
			tgt_reg <= tgt_next;
			data_reg <= data_next;
			ntf_reg <= ntf_next;
			rel_reg <= rel_next;
			rsp_reg[0] <= rsp_next[0];
			rsp_reg[1] <= rsp_next[1];
		end
	end

	// Per-CPU aggregate of pending events
	logic ipc_main_reg, ipc_main_next, ipc_sec_reg, ipc_sec_next;
	always_comb begin
		ipc_main_next = |((ntf_next | rel_next) & ~tgt_next);
		ipc_sec_next = |((ntf_next | rel_next) & tgt_next);
	end

	// Per-CPU aggregate registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ipc_main_reg <= 1'b0;
			ipc_sec_reg <= 1'b0;
		end else begin
			ipc_main_reg <= ipc_main_next;
			ipc_sec_reg <= ipc_sec_next;
		end
	end

	// Outputs straight from flops
	assign main_irq_o = main_irq_reg;
	assign main_top_valid_o = main_top_valid_reg;
	assign main_top_id_o = main_top_id_reg;
	assign main_top_prio_o = main_top_prio_reg;
	assign sec_irq_o = sec_irq_reg;
	assign sec_sw_pend_o = sw_pend_reg;
	assign sec_top_valid_o = sec_top_valid_reg;
	assign sec_top_id_o = sec_top_id_reg;
	assign sec_top_prio_o = sec_top_prio_reg;
	assign main_nmi_o = main_nmi_reg;
	assign sec_nmi_o = sec_nmi_reg;
	assign wake_o = wake_reg;
	assign ipc_rsp_main_o = rsp_reg[0];
	assign ipc_rsp_sec_o = rsp_reg[1];
	assign ipc_lock_o = lock_reg;
	assign ipc_notify_o = ntf_reg;
	assign ipc_release_o = rel_reg;
	assign ipc_irq_main_o = ipc_main_reg;
	assign ipc_irq_sec_o = ipc_sec_reg;
endmodule // dcir_router

// >>> dcir_consts.svh
// Constants for the dual-CPU interrupt and inter-processor router
// Overview of operation
// - Each of the 174 sources drives main CPU request line n one-to-one, with no remapping.
// - Eight secondary CPU lines each OR together their own independently selected set of sources.
// - Eight more secondary CPU interrupts are raised and cleared only by software.
// - Each interrupt has a priority: eight levels for the main CPU, four for the secondary.
// - Each CPU's non-maskable input is driven by up to four selected system sources.
// - Up to 39 sources can raise deep-sleep wake, even while the interrupt units are stopped.
// - Sixteen inter-processor channels each carry a lock that grants one owner at a time.
// - Each channel holds a data word written by one processor and read by the other.
// - Sixteen interrupt structures carry notify and release events to the other processor.
// - A system-function request from either CPU or the debug port raises the secondary NMI.
`ifndef DCIR_CONSTS_SVH
`define DCIR_CONSTS_SVH
`define DCIR_SRC_N 174
`define DCIR_SRC_W 8
`define DCIR_MAIN_PW 3
`define DCIR_SEC_LINES 8
`define DCIR_SEC_SW 8
`define DCIR_SEC_N 16
`define DCIR_SEC_W 4
`define DCIR_SEC_PW 2
`define DCIR_NMI_SEL 4
`define DCIR_WAKE_N 39
`define DCIR_CH_N 16
`define DCIR_CH_W 4
`define DCIR_DATA_W 32
`endif

// >>> dcir_pkg.sv
// Types shared by the router and its users
`include "dcir_consts.svh"
package dcir_pkg;
	typedef enum logic [2:0] {
		IPC_NOP,
		IPC_ACQUIRE,
		IPC_RELEASE,
		IPC_WRITE,
		IPC_READ,
		IPC_NOTIFY,
		IPC_CLEAR
	} dcir_ipc_op_type;

	typedef struct packed {
		dcir_ipc_op_type op;
		logic [`DCIR_CH_W-1:0] chan;
		logic [`DCIR_DATA_W-1:0] data;
	} dcir_ipc_req_type;

	typedef struct packed {
		logic valid;
		logic ok;
		logic [`DCIR_DATA_W-1:0] rdata;
	} dcir_ipc_rsp_type;

	typedef struct packed {
		logic [`DCIR_NMI_SEL-1:0] en;
		logic [`DCIR_NMI_SEL-1:0][`DCIR_SRC_W-1:0] idx;
	} dcir_nmi_sel_type;
endpackage

// >>> dcir_router_props.sv
// Port checker for the dual-CPU router
`timescale 1ns/1ps
`include "dcir_consts.svh"
module dcir_router_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [`DCIR_SRC_N-1:0] src_irq_i,
	input wire logic irq_units_run_i,
	input wire logic [`DCIR_WAKE_N-1:0] wake_mask_i,
	input wire logic [`DCIR_SEC_SW-1:0] sec_sw_set_i,
	input wire logic sysfn_main_i,
	input wire dcir_pkg::dcir_ipc_req_type ipc_req_main_i,
	input wire logic [`DCIR_SRC_N-1:0] main_irq_o,
	input wire logic [`DCIR_SEC_SW-1:0] sec_sw_pend_o,
	input wire logic sec_nmi_o,
	input wire logic wake_o,
	input wire dcir_pkg::dcir_ipc_rsp_type ipc_rsp_main_o,
	input wire logic [`DCIR_CH_N-1:0] ipc_lock_o,
	input wire logic [`DCIR_CH_N-1:0] ipc_notify_o,
	input wire logic ipc_irq_sec_o
);
	logic [1:0] age_reg;
	logic live;
	// Settle count so past values never reach into reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) age_reg <= 2'h0;
		else if (!live) age_reg <= age_reg + 2'h1;
	end
	assign live = (age_reg == 2'h3);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	main_copy_a: assert property (live && $past(irq_units_run_i) |->
		main_irq_o == $past(src_irq_i))
		else $error("main line mismatch");
	wake_level_a: assert property (live |-> wake_o == |$past(src_irq_i[38:0] & wake_mask_i))
		else $error("wake mismatch");
	rsp_pulse_a: assert property (live |->
		ipc_rsp_main_o.valid == ($past(ipc_req_main_i.op) != 3'h0))
		else $error("response pulse mismatch");
	acquire_grant_a: assert property (ipc_req_main_i.op == dcir_pkg::IPC_ACQUIRE &&
		!ipc_lock_o[ipc_req_main_i.chan] |=> ipc_rsp_main_o.ok && ipc_lock_o[$past(ipc_req_main_i.chan)])
		else $error("free acquire not granted");
	acquire_refuse_a: assert property (ipc_req_main_i.op == dcir_pkg::IPC_ACQUIRE &&
		ipc_lock_o[ipc_req_main_i.chan] |=> !ipc_rsp_main_o.ok)
		else $error("locked acquire granted");
	notify_raise_a: assert property (ipc_req_main_i.op == dcir_pkg::IPC_NOTIFY |=>
		ipc_notify_o[$past(ipc_req_main_i.chan)] && ipc_irq_sec_o)
		else $error("notify not raised");
	sysfn_nmi_a: assert property (live && sysfn_main_i |-> ##2 sec_nmi_o)
		else $error("system function nmi missing");
	sw_set_a: assert property (live && $past(sec_sw_set_i) != 8'h00 |->
		(sec_sw_pend_o & $past(sec_sw_set_i)) == $past(sec_sw_set_i))
		else $error("software pend missing");
	cover property (ipc_req_main_i.op == dcir_pkg::IPC_ACQUIRE ##1 ipc_rsp_main_o.ok);
	cover property (ipc_req_main_i.op == dcir_pkg::IPC_NOTIFY);
	cover property (sysfn_main_i ##2 sec_nmi_o);
endmodule // dcir_router_props
bind dcir_router dcir_router_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.src_irq_i(src_irq_i), .irq_units_run_i(irq_units_run_i), .wake_mask_i(wake_mask_i),
	.sec_sw_set_i(sec_sw_set_i), .sysfn_main_i(sysfn_main_i), .ipc_req_main_i(ipc_req_main_i),
	.main_irq_o(main_irq_o), .sec_sw_pend_o(sec_sw_pend_o), .sec_nmi_o(sec_nmi_o),
	.wake_o(wake_o), .ipc_rsp_main_o(ipc_rsp_main_o), .ipc_lock_o(ipc_lock_o),
	.ipc_notify_o(ipc_notify_o), .ipc_irq_sec_o(ipc_irq_sec_o));

// >>> dcir_sec_core.sv
// Secondary core model that answers channel notify events
`timescale 1ns/1ps
module dcir_sec_core #(
	parameter logic [3:0] CHAN = 4'h3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic irq_i,
	input wire dcir_pkg::dcir_ipc_rsp_type rsp_i,
	input wire dcir_pkg::dcir_ipc_req_type host_i,
	output dcir_pkg::dcir_ipc_req_type req_o,
	output logic [31:0] got_o
);
	logic irq_reg;
	logic [1:0] ph_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_reg <= 1'b0;
			ph_reg <= 2'h0;
			got_o <= 32'h0;
		end else begin
			irq_reg <= irq_i;
			ph_reg <= (irq_i && !irq_reg) ? 2'h1 : {ph_reg == 2'h1, 1'b0};
			if (ph_reg == 2'h2 && rsp_i.valid) got_o <= rsp_i.rdata;
		end
	end
	always_comb begin
		req_o = host_i;
		if (ph_reg == 2'h1) req_o = '{dcir_pkg::IPC_READ, CHAN, 32'h0};
		if (ph_reg == 2'h2) req_o = '{dcir_pkg::IPC_CLEAR, CHAN, 32'h0};
	end
endmodule // dcir_sec_core

// >>> dcir_router_bench.sv
// Self-checking bench for the dual-CPU router
`timescale 1ns/1ps
`include "dcir_consts.svh"
module dcir_router_bench;
	logic clk_i, rst_n_i, irq_units_run_i, main_top_valid_o, sec_top_valid_o, main_nmi_o;
	logic sysfn_main_i, sysfn_sec_i, sysfn_debug_port_i, sysfn_ack_i, wake_o, sec_nmi_o;
	logic ipc_irq_main_o, ipc_irq_sec_o;
	logic [`DCIR_SRC_N-1:0] src_irq_i, main_en_i, main_irq_o;
	logic [`DCIR_SRC_N*`DCIR_MAIN_PW-1:0] main_prio_i;
	logic [`DCIR_SEC_LINES*`DCIR_SRC_N-1:0] sec_map_i;
	logic [15:0] sec_en_i, ipc_lock_o, ipc_notify_o, ipc_release_o;
	logic [31:0] sec_prio_i, got;
	logic [7:0] sec_sw_set_i, sec_sw_clr_i, sec_irq_o, sec_sw_pend_o, main_top_id_o;
	logic [3:0] sec_top_id_o;
	logic [2:0] main_top_prio_o;
	logic [1:0] sec_top_prio_o;
	logic [`DCIR_WAKE_N-1:0] wake_mask_i;
	dcir_pkg::dcir_nmi_sel_type main_nmi_sel_i, sec_nmi_sel_i;
	dcir_pkg::dcir_ipc_req_type ipc_req_main_i, ipc_req_sec_i, host_req;
	dcir_pkg::dcir_ipc_rsp_type ipc_rsp_main_o, ipc_rsp_sec_o;
	int bad_count, num_checks;
	dcir_router u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_irq_i(src_irq_i),
		.irq_units_run_i(irq_units_run_i), .main_en_i(main_en_i), .main_prio_i(main_prio_i),
		.sec_map_i(sec_map_i), .sec_en_i(sec_en_i), .sec_prio_i(sec_prio_i),
		.sec_sw_set_i(sec_sw_set_i), .sec_sw_clr_i(sec_sw_clr_i), .main_nmi_sel_i(main_nmi_sel_i),
		.sec_nmi_sel_i(sec_nmi_sel_i), .sysfn_main_i(sysfn_main_i), .sysfn_sec_i(sysfn_sec_i),
		.sysfn_debug_port_i(sysfn_debug_port_i), .sysfn_ack_i(sysfn_ack_i),
		.wake_mask_i(wake_mask_i), .ipc_req_main_i(ipc_req_main_i), .ipc_req_sec_i(ipc_req_sec_i),
		.main_irq_o(main_irq_o), .main_top_valid_o(main_top_valid_o),
		.main_top_id_o(main_top_id_o), .main_top_prio_o(main_top_prio_o), .sec_irq_o(sec_irq_o),
		.sec_sw_pend_o(sec_sw_pend_o), .sec_top_valid_o(sec_top_valid_o),
		.sec_top_id_o(sec_top_id_o), .sec_top_prio_o(sec_top_prio_o), .main_nmi_o(main_nmi_o),
		.sec_nmi_o(sec_nmi_o), .wake_o(wake_o), .ipc_rsp_main_o(ipc_rsp_main_o),
		.ipc_rsp_sec_o(ipc_rsp_sec_o), .ipc_lock_o(ipc_lock_o), .ipc_notify_o(ipc_notify_o),
		.ipc_release_o(ipc_release_o), .ipc_irq_main_o(ipc_irq_main_o),
		.ipc_irq_sec_o(ipc_irq_sec_o));
	dcir_sec_core u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_i(ipc_irq_sec_o),
		.rsp_i(ipc_rsp_sec_o), .host_i(host_req), .req_o(ipc_req_sec_i), .got_o(got));
	// Clock and watchdog
	initial clk_i = 1'b0;
	always #4 clk_i = ~clk_i;
	initial begin
		#5000;
		bad_count++;
		final_report;
	end
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task chk(input logic [191:0] g, input logic [191:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One channel request on either port, response checked a cycle later
	task chan_op(input logic s, input dcir_pkg::dcir_ipc_op_type op, input logic [3:0] ch,
		input logic [31:0] d, input logic ok);
		if (s) host_req = '{op, ch, d};
		else ipc_req_main_i = '{op, ch, d};
		step(1);
		host_req = '0;
		ipc_req_main_i = '0;
		chk(s ? {ipc_rsp_sec_o.valid, ipc_rsp_sec_o.ok} : {ipc_rsp_main_o.valid, ipc_rsp_main_o.ok},
			{1'b1, ok});
		step(1);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		{irq_units_run_i, sysfn_main_i, sysfn_sec_i, sysfn_debug_port_i, sysfn_ack_i} = 5'h10;
		src_irq_i = '0;
		main_en_i = '1;
		main_prio_i = '1;
		sec_map_i = '0;
		sec_en_i = '1;
		sec_prio_i = '1;
		sec_sw_set_i = 8'h00;
		sec_sw_clr_i = 8'h00;
		wake_mask_i = '0;
		main_nmi_sel_i = '0;
		sec_nmi_sel_i = '0;
		host_req = '0;
		ipc_req_main_i = '0;
		bad_count = 0;
		num_checks = 0;
		step(2);
		rst_n_i = 1'b1;
		src_irq_i[9:0] = 10'h220;
		main_prio_i[17:15] = 3'h5;
		main_prio_i[29:27] = 3'h2;
		sec_map_i[3*`DCIR_SRC_N+9] = 1'b1;
		wake_mask_i[5] = 1'b1;
		step(2);
		chk(main_irq_o[9:0], 10'h220);
		chk({main_top_id_o, main_top_prio_o}, {8'h09, 3'h2});
		chk({sec_irq_o, wake_o}, {8'h08, 1'b1});
		main_prio_i[17:15] = 3'h2;
		step(1);
		chk(main_top_id_o, 8'h05);
		irq_units_run_i = 1'b0;
		step(1);
		chk({main_irq_o[9:0], main_top_valid_o, wake_o}, {10'h0, 1'b0, 1'b1});
		irq_units_run_i = 1'b1;
		main_nmi_sel_i.en = 4'h8;
		main_nmi_sel_i.idx[3] = 8'h05;
		step(1);
		chk(main_nmi_o, 1'b1);
		main_nmi_sel_i.idx[3] = 8'hc8;
		step(1);
		chk(main_nmi_o, 1'b0);
		$display("test routing done");
		sec_prio_i[21:20] = 2'h0;
		sec_sw_set_i = 8'h04;
		step(1);
		sec_sw_set_i = 8'h00;
		chk(sec_sw_pend_o, 8'h04);
		step(1);
		chk({sec_top_valid_o, sec_top_id_o, sec_top_prio_o}, {1'b1, 4'ha, 2'h0});
		sec_sw_clr_i = 8'h04;
		step(1);
		sec_sw_clr_i = 8'h00;
		chk(sec_sw_pend_o, 8'h00);
		sysfn_debug_port_i = 1'b1;
		step(4);
		chk(sec_nmi_o, 1'b1);
		sysfn_debug_port_i = 1'b0;
		sysfn_ack_i = 1'b1;
		step(4);
		sysfn_ack_i = 1'b0;
		chk(sec_nmi_o, 1'b0);
		sysfn_main_i = 1'b1;
		step(1);
		sysfn_main_i = 1'b0;
		step(1);
		chk(sec_nmi_o, 1'b1);
		sysfn_ack_i = 1'b1;
		step(1);
		sysfn_ack_i = 1'b0;
		step(1);
		chk(sec_nmi_o, 1'b0);
		sysfn_sec_i = 1'b1;
		step(1);
		sysfn_sec_i = 1'b0;
		step(1);
		chk(sec_nmi_o, 1'b1);
		$display("test software and nmi done");
		chan_op(1'b0, dcir_pkg::IPC_ACQUIRE, 4'h3, 32'h0, 1'b1);
		chk(ipc_lock_o, 16'h0008);
		chan_op(1'b0, dcir_pkg::IPC_ACQUIRE, 4'h3, 32'h0, 1'b0);
		chan_op(1'b1, dcir_pkg::IPC_ACQUIRE, 4'h3, 32'h0, 1'b0);
		chan_op(1'b1, dcir_pkg::IPC_RELEASE, 4'h3, 32'h0, 1'b0);
		chan_op(1'b0, dcir_pkg::IPC_WRITE, 4'h3, 32'hc0de1234, 1'b1);
		chan_op(1'b0, dcir_pkg::IPC_NOTIFY, 4'h3, 32'h0, 1'b1);
		step(4);
		chk({got, ipc_notify_o}, {32'hc0de1234, 16'h0});
		chan_op(1'b0, dcir_pkg::IPC_RELEASE, 4'h3, 32'h0, 1'b1);
		chk({ipc_lock_o, ipc_release_o, ipc_irq_sec_o}, {16'h0, 16'h0008, 1'b1});
		chan_op(1'b0, dcir_pkg::IPC_ACQUIRE, 4'hf, 32'h0, 1'b1);
		chk(ipc_lock_o, 16'h8000);
		chan_op(1'b1, dcir_pkg::IPC_NOTIFY, 4'h3, 32'h0, 1'b1);
		chk({ipc_irq_main_o, ipc_irq_sec_o}, 2'h2);
		chan_op(1'b0, dcir_pkg::IPC_CLEAR, 4'h3, 32'h0, 1'b1);
		chk({ipc_irq_main_o, ipc_notify_o}, {1'b0, 16'h0});
		$display("test channels done");
		final_report;
	end
endmodule // dcir_router_bench
